//--- verilog/irq_ctrl_pkg.sv
/*
 * Constants shared by the two-level interrupt controller: register
 * addresses, reset values, field positions, poll order and vectors.
 * Assumes an 8-bit special-function register space with bit addressing.
 */
package irq_ctrl_pkg;

	// ---------------------------------------------------------------
	// register addresses and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_IRQ_ENABLE_PRIMARY  = 8'h00_A8;
	localparam logic [7:0] ADDR_IRQ_EN_PRIO_SECOND  = 8'h00_A9;
	localparam logic [7:0] ADDR_IRQ_PRIORITY_PRIM   = 8'h00_B8;
	localparam logic [7:0] RST_IRQ_ENABLE_PRIMARY   = 8'h00_00;
	localparam logic [7:0] RST_IRQ_EN_PRIO_SECOND   = 8'h00_A0;
	localparam logic [7:0] RST_IRQ_PRIORITY_PRIM    = 8'h00_00;
	localparam logic [7:0] RESERVED_MASK_PRIO_PRIM  = 8'h00_7F;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int BIT_GLOBAL    = 7;
	localparam int BIT_CONVERTER = 6;
	localparam int BIT_TIMER2    = 5;
	localparam int BIT_UART      = 4;
	localparam int BIT_TIMER1    = 3;
	localparam int BIT_EXT1      = 2;
	localparam int BIT_TIMER0    = 1;
	localparam int BIT_EXT0      = 0;
	localparam int BIT2_TIC_LVL  = 6;
	localparam int BIT2_PSM_LVL  = 5;
	localparam int BIT2_SER_LVL  = 4;
	localparam int BIT2_TIC_EN   = 2;
	localparam int BIT2_PSM_EN   = 1;
	localparam int BIT2_SER_EN   = 0;

	// ---------------------------------------------------------------
	// poll order, index 0 wins
	// ---------------------------------------------------------------
	localparam int NUM_SRC   = 11;
	localparam int IDX_W     = 4;
	localparam int POLL_PSM  = 0;
	localparam int POLL_WDT  = 1;
	localparam int POLL_EXT0 = 2;
	localparam int POLL_ADC  = 3;
	localparam int POLL_T0   = 4;
	localparam int POLL_EXT1 = 5;
	localparam int POLL_T1   = 6;
	localparam int POLL_SER  = 7;
	localparam int POLL_UART = 8;
	localparam int POLL_T2   = 9;
	localparam int POLL_TIC  = 10;

	// ---------------------------------------------------------------
	// vectors
	// ---------------------------------------------------------------
	localparam logic [15:0] VEC_EXT0 = 16'h0003;
	localparam logic [15:0] VEC_T0   = 16'h000B;
	localparam logic [15:0] VEC_EXT1 = 16'h0013;
	localparam logic [15:0] VEC_T1   = 16'h001B;
	localparam logic [15:0] VEC_UART = 16'h0023;
	localparam logic [15:0] VEC_T2   = 16'h002B;
	localparam logic [15:0] VEC_ADC  = 16'h0033;
	localparam logic [15:0] VEC_SER  = 16'h003B;
	localparam logic [15:0] VEC_PSM  = 16'h0043;
	localparam logic [15:0] VEC_TIC  = 16'h0053;
	localparam logic [15:0] VEC_WDT  = 16'h005B;

	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'b00,
		SEQ_PUSH_LO = 2'b01,
		SEQ_PUSH_HI = 2'b11,
		SEQ_LOAD    = 2'b10
	} seq_state_t;

	function automatic logic [15:0] vector_of(input logic [IDX_W-1:0] idx);
		logic [15:0] v;
		v = VEC_TIC;
		case (idx)
			IDX_W'(POLL_PSM):  v = VEC_PSM;
			IDX_W'(POLL_WDT):  v = VEC_WDT;
			IDX_W'(POLL_EXT0): v = VEC_EXT0;
			IDX_W'(POLL_ADC):  v = VEC_ADC;
			IDX_W'(POLL_T0):   v = VEC_T0;
			IDX_W'(POLL_EXT1): v = VEC_EXT1;
			IDX_W'(POLL_T1):   v = VEC_T1;
			IDX_W'(POLL_SER):  v = VEC_SER;
			IDX_W'(POLL_UART): v = VEC_UART;
			IDX_W'(POLL_T2):   v = VEC_T2;
			default:           v = VEC_TIC;
		endcase
		return v;
	endfunction : vector_of

endpackage : irq_ctrl_pkg

//--- verilog/prio_pick.sv
/*
 * Fixed-order picker: lowest set index of a request vector wins.
 * Assumes a purely combinational use inside one clock domain.
 */
`timescale 1ns/1ps
module prio_pick #(
	parameter int N  = 11,
	parameter int IW = 4
) (
	input  wire logic [N-1:0]  req,   // requests in poll order
	output logic               found, // any request set
	output logic [IW-1:0]      idx    // winning index
);

	always_comb
	begin
		found = 1'b0;
		idx   = '0;
		// walk downward so the lowest index is assigned last
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				found = 1'b1;
				idx   = IW'(i);
			end
		end
	end

endmodule : prio_pick

//--- verilog/two_level_interrupt_controller.sv
/*
 * Two-level interrupt controller: three special-function registers,
 * source gating, level arbitration, fixed polling, vector sequencing.
 * Assumes the core samples the byte/vector strobes on sys_clk with ce
 * high and pulses return_from_isr once per service-routine return.
 */
`timescale 1ns/1ps
module two_level_interrupt_controller
	import irq_ctrl_pkg::*;
#(
	parameter int WDT_SET_W = 4
) (
	input  wire logic                 sys_clk,               // core clock
	input  wire logic                 rst_b,                 // async reset, active low
	input  wire logic                 ce,                    // clock enable
	input  wire logic [7:0]           sfr_addr,              // register address
	input  wire logic                 sfr_wr,                // byte write strobe
	input  wire logic                 sfr_rd,                // byte read strobe
	input  wire logic [7:0]           sfr_wdata,             // byte write data
	output logic      [7:0]           sfr_rdata,             // read data, next cycle
	output logic                      sfr_hit,               // address owned here
	input  wire logic [7:0]           bit_addr,              // bit address
	input  wire logic                 bit_wr,                // bit write strobe
	input  wire logic                 bit_wdata,             // bit write value
	input  wire logic                 supply_monitor_flag,   // supply monitor request
	input  wire logic                 ext0_flag,             // external 0 request
	input  wire logic                 main_converter_ready,  // main converter done
	input  wire logic                 aux_converter_ready,   // aux converter done
	input  wire logic                 timer0_overflow,       // timer 0 request
	input  wire logic                 ext1_flag,             // external 1 request
	input  wire logic                 timer1_overflow,       // timer 1 request
	input  wire logic                 serial_periph_flag,    // serial periph request
	input  wire logic                 two_wire_flag,         // two-wire request
	input  wire logic                 uart_rx_done,          // uart receive done
	input  wire logic                 uart_tx_done,          // uart transmit done
	input  wire logic                 timer2_overflow,       // timer 2 overflow
	input  wire logic                 timer2_external_flag,  // timer 2 external flag
	input  wire logic                 interval_counter_flag, // interval counter request
	input  wire logic                 wdt_timeout,           // watchdog timeout pulse
	input  wire logic                 watchdog_irq_select,   // 1 = interrupt, 0 = reset
	input  wire logic [WDT_SET_W-1:0] wdt_timeout_setting,   // watchdog timeout setting
	output logic                      watchdog_flag,         // watchdog request pending
	output logic                      wdt_reset_req,         // watchdog reset pulse
	input  wire logic                 instr_boundary,        // core may be interrupted
	input  wire logic [15:0]          current_pc,            // pc to be saved
	input  wire logic                 return_from_isr,       // routine return pulse
	output logic                      irq_pending,           // a request may be taken
	output logic                      stack_push,            // push byte strobe
	output logic      [7:0]           stack_byte,            // byte to push
	output logic                      pc_load,               // vector load strobe
	output logic      [15:0]          pc_load_addr,          // vector address
	output logic      [NUM_SRC-1:0]   irq_ack,               // taken source, poll order
	output logic                      in_service_hi,         // high routine active
	output logic                      in_service_lo,         // low routine active
	output logic                      seq_busy               // vectoring in progress
);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] irq_enable_primary;
	logic [7:0] irq_enable_priority_secondary;
	logic [7:0] irq_priority_primary;

	wire        sel_en_prim  = (sfr_addr == ADDR_IRQ_ENABLE_PRIMARY);
	wire        sel_en_sec   = (sfr_addr == ADDR_IRQ_EN_PRIO_SECOND);
	wire        sel_prio     = (sfr_addr == ADDR_IRQ_PRIORITY_PRIM);
	wire        bit_en_prim  = (bit_addr[7:3] == ADDR_IRQ_ENABLE_PRIMARY[7:3]);
	wire        bit_prio     = (bit_addr[7:3] == ADDR_IRQ_PRIORITY_PRIM[7:3]);
	wire [7:0]  bit_onehot   = 8'h00_01 << bit_addr[2:0];
	wire        wr_en_prim   = sfr_wr && sel_en_prim;
	wire        wr_en_sec    = sfr_wr && sel_en_sec;
	wire        wr_prio      = sfr_wr && sel_prio;
	wire        bwr_en_prim  = bit_wr && bit_en_prim;
	wire        bwr_prio     = bit_wr && bit_prio;

	// a bit write touches one bit only; the rest is kept
	wire [7:0]  bit_merge_en = bit_wdata ? (irq_enable_primary | bit_onehot)
	                                     : (irq_enable_primary & ~bit_onehot);
	wire [7:0]  bit_merge_pr = bit_wdata ? (irq_priority_primary | bit_onehot)
	                                     : (irq_priority_primary & ~bit_onehot);

	wire [7:0]  next_en_prim = wr_en_prim  ? sfr_wdata
	                         : bwr_en_prim ? bit_merge_en
	                         : irq_enable_primary;
	wire [7:0]  next_prio    = wr_prio  ? (sfr_wdata & RESERVED_MASK_PRIO_PRIM)
	                         : bwr_prio ? (bit_merge_pr & RESERVED_MASK_PRIO_PRIM)
	                         : irq_priority_primary;

	// bit 3 is stored as written: keeping it zero is up to software
	wire [7:0]  next_en_sec  = wr_en_sec ? sfr_wdata
	                         : irq_enable_priority_secondary;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_enable_primary            <= RST_IRQ_ENABLE_PRIMARY;
			irq_enable_priority_secondary <= RST_IRQ_EN_PRIO_SECOND;
			irq_priority_primary          <= RST_IRQ_PRIORITY_PRIM;
		end
		else if (ce)
		begin
			irq_enable_primary            <= next_en_prim;
			irq_enable_priority_secondary <= next_en_sec;
			irq_priority_primary          <= next_prio;
		end
	end

	// ---------------------------------------------------------------
	// register read
	// ---------------------------------------------------------------
	assign sfr_hit = sel_en_prim || sel_en_sec || sel_prio;

	wire [7:0] rd_mux = sel_en_prim ? irq_enable_primary
	                  : sel_en_sec  ? irq_enable_priority_secondary
	                  : sel_prio    ? irq_priority_primary
	                  : 8'h00_00;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			sfr_rdata <= 8'h00_00;
		else if (ce && sfr_rd)
			sfr_rdata <= rd_mux;
	end

	// ---------------------------------------------------------------
	// watchdog request
	// ---------------------------------------------------------------
	wire wdt_armed    = (wdt_timeout_setting != '0);
	wire wdt_irq_set  = wdt_timeout && watchdog_irq_select && wdt_armed;
	wire wdt_irq_clr;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			watchdog_flag <= 1'b0;
			wdt_reset_req <= 1'b0;
		end
		else if (ce)
		begin
			// a new timeout in the clearing cycle is kept
			watchdog_flag <= wdt_irq_set || (watchdog_flag && !wdt_irq_clr);
			wdt_reset_req <= wdt_timeout && !watchdog_irq_select;
		end
	end

	// ---------------------------------------------------------------
	// source gating, poll order index 0 first
	// ---------------------------------------------------------------
	wire              glb = irq_enable_primary[BIT_GLOBAL];
	wire [7:0]        en  = irq_enable_primary;
	wire [7:0]        e2  = irq_enable_priority_secondary;
	wire [7:0]        pr  = irq_priority_primary;
	wire [NUM_SRC-1:0] flag_v;
	wire [NUM_SRC-1:0] en_v;
	wire [NUM_SRC-1:0] level_v;

	assign flag_v[POLL_PSM]  = supply_monitor_flag;
	assign flag_v[POLL_WDT]  = watchdog_flag;
	assign flag_v[POLL_EXT0] = ext0_flag;
	assign flag_v[POLL_ADC]  = main_converter_ready || aux_converter_ready;
	assign flag_v[POLL_T0]   = timer0_overflow;
	assign flag_v[POLL_EXT1] = ext1_flag;
	assign flag_v[POLL_T1]   = timer1_overflow;
	assign flag_v[POLL_SER]  = serial_periph_flag || two_wire_flag;
	assign flag_v[POLL_UART] = uart_rx_done || uart_tx_done;
	assign flag_v[POLL_T2]   = timer2_overflow || timer2_external_flag;
	assign flag_v[POLL_TIC]  = interval_counter_flag;

	// watchdog ignores the global gate
	assign en_v[POLL_PSM]  = glb && e2[BIT2_PSM_EN];
	assign en_v[POLL_WDT]  = 1'b1;
	assign en_v[POLL_EXT0] = glb && en[BIT_EXT0];
	assign en_v[POLL_ADC]  = glb && en[BIT_CONVERTER];
	assign en_v[POLL_T0]   = glb && en[BIT_TIMER0];
	assign en_v[POLL_EXT1] = glb && en[BIT_EXT1];
	assign en_v[POLL_T1]   = glb && en[BIT_TIMER1];
	assign en_v[POLL_SER]  = glb && e2[BIT2_SER_EN];
	assign en_v[POLL_UART] = glb && en[BIT_UART];
	assign en_v[POLL_T2]   = glb && en[BIT_TIMER2];
	assign en_v[POLL_TIC]  = glb && e2[BIT2_TIC_EN];

	assign level_v[POLL_PSM]  = e2[BIT2_PSM_LVL];
	assign level_v[POLL_WDT]  = 1'b1;
	assign level_v[POLL_EXT0] = pr[BIT_EXT0];
	assign level_v[POLL_ADC]  = pr[BIT_CONVERTER];
	assign level_v[POLL_T0]   = pr[BIT_TIMER0];
	assign level_v[POLL_EXT1] = pr[BIT_EXT1];
	assign level_v[POLL_T1]   = pr[BIT_TIMER1];
	assign level_v[POLL_SER]  = e2[BIT2_SER_LVL];
	assign level_v[POLL_UART] = pr[BIT_UART];
	assign level_v[POLL_T2]   = pr[BIT_TIMER2];
	assign level_v[POLL_TIC]  = e2[BIT2_TIC_LVL];

	wire [NUM_SRC-1:0] live_v = flag_v & en_v;
	wire [NUM_SRC-1:0] req_hi = live_v & level_v;
	wire [NUM_SRC-1:0] req_lo = live_v & ~level_v;

	// ---------------------------------------------------------------
	// arbitration
	// ---------------------------------------------------------------
	logic             hi_found;
	logic             lo_found;
	logic [IDX_W-1:0] hi_idx;
	logic [IDX_W-1:0] lo_idx;

	prio_pick #(
		.N  (NUM_SRC),
		.IW (IDX_W)
	) u_pick_hi (
		.req   (req_hi),
		.found (hi_found),
		.idx   (hi_idx)
	);

	prio_pick #(
		.N  (NUM_SRC),
		.IW (IDX_W)
	) u_pick_lo (
		.req   (req_lo),
		.found (lo_found),
		.idx   (lo_idx)
	);

	// high may cut into low; nothing cuts into its own level
	wire hi_ok   = hi_found && !in_service_hi;
	wire lo_ok   = lo_found && !in_service_hi && !in_service_lo;
	wire take_hi = hi_ok;
	wire take_ok = hi_ok || lo_ok;
	wire [IDX_W-1:0] take_idx = take_hi ? hi_idx : lo_idx;

	// ---------------------------------------------------------------
	// vectoring sequence
	// ---------------------------------------------------------------
	seq_state_t       state;
	seq_state_t       next_state;
	logic [15:0]      saved_pc;
	logic [IDX_W-1:0] saved_idx;
	logic             saved_hi;

	assign seq_busy    = (state != SEQ_IDLE);
	assign irq_pending = take_ok && !seq_busy;

	wire accept = irq_pending && instr_boundary;

	always_comb
	begin
		next_state = state;
		unique case (state)
			SEQ_IDLE:    next_state = accept ? SEQ_PUSH_LO : SEQ_IDLE;
			SEQ_PUSH_LO: next_state = SEQ_PUSH_HI;
			SEQ_PUSH_HI: next_state = SEQ_LOAD;
			SEQ_LOAD:    next_state = SEQ_IDLE;
		endcase
	end

	wire in_load = (state == SEQ_LOAD);
	wire [NUM_SRC-1:0] ack_onehot = in_load ? (NUM_SRC'(1) << saved_idx) : '0;
	assign wdt_irq_clr = ack_onehot[POLL_WDT];

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state     <= SEQ_IDLE;
			saved_pc  <= 16'h0000;
			saved_idx <= '0;
			saved_hi  <= 1'b0;
		end
		else if (ce)
		begin
			state <= next_state;
			if (accept)
			begin
				saved_pc  <= current_pc;
				saved_idx <= take_idx;
				saved_hi  <= take_hi;
			end
		end
	end

	// ---------------------------------------------------------------
	// core-facing strobes, low byte pushed first
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stack_push   <= 1'b0;
			stack_byte   <= 8'h00_00;
			pc_load      <= 1'b0;
			pc_load_addr <= 16'h0000;
			irq_ack      <= '0;
		end
		else if (ce)
		begin
			stack_push <= (state == SEQ_PUSH_LO) || (state == SEQ_PUSH_HI);
			if (state == SEQ_PUSH_LO)
				stack_byte <= saved_pc[7:0];
			else if (state == SEQ_PUSH_HI)
				stack_byte <= saved_pc[15:8];
			pc_load <= in_load;
			if (in_load)
				pc_load_addr <= vector_of(saved_idx);
			irq_ack <= ack_onehot;
		end
	end

	// ---------------------------------------------------------------
	// in-service levels
	// ---------------------------------------------------------------
	// a return ends the higher active level; a set in the same cycle wins
	wire ret_hi = return_from_isr && in_service_hi;
	wire ret_lo = return_from_isr && !in_service_hi && in_service_lo;
	wire set_hi = in_load && saved_hi;
	wire set_lo = in_load && !saved_hi;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			in_service_hi <= 1'b0;
			in_service_lo <= 1'b0;
		end
		else if (ce)
		begin
			in_service_hi <= set_hi || (in_service_hi && !ret_hi);
			in_service_lo <= set_lo || (in_service_lo && !ret_lo);
		end
	end

endmodule : two_level_interrupt_controller

//--- bench/irq_ctrl_asserts.sv
/*
 * Checks on the controller's core link and watchdog ports.
 * Assumes a bind into the controller top, with ce held high.
 */
`timescale 1ns/1ps
module irq_ctrl_asserts
	import irq_ctrl_pkg::*;
#(
	parameter int WDT_SET_W = 4
) (
	input wire logic                 sys_clk,             // core clock
	input wire logic                 rst_b,               // async reset, active low
	input wire logic                 instr_boundary,      // core interruptible
	input wire logic [15:0]          current_pc,          // pc to save
	input wire logic                 return_from_isr,     // return pulse
	input wire logic                 irq_pending,         // takeable request
	input wire logic                 stack_push,          // push strobe
	input wire logic [7:0]           stack_byte,          // pushed byte
	input wire logic                 pc_load,             // vector strobe
	input wire logic [15:0]          pc_load_addr,        // vector
	input wire logic [NUM_SRC-1:0]   irq_ack,             // taken source
	input wire logic                 in_service_hi,       // high active
	input wire logic                 in_service_lo,       // low active
	input wire logic                 seq_busy,            // sequencing
	input wire logic                 wdt_timeout,         // timeout pulse
	input wire logic                 watchdog_irq_select, // interrupt mode
	input wire logic [WDT_SET_W-1:0] wdt_timeout_setting, // timeout setting
	input wire logic                 watchdog_flag,       // watchdog pending
	input wire logic                 wdt_reset_req        // reset pulse
);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_accept; irq_pending && instr_boundary && !seq_busy; endsequence
	sequence s_vector; stack_push [*2] ##1 (pc_load && $onehot(irq_ack)); endsequence
	chk_push_then_load: assert property (s_accept |=> !stack_push ##1 s_vector)
		else $error("push and load out of order");
	chk_pc_bytes: assert property (s_accept |-> ##2 ({8'h00, stack_byte} == ($past(current_pc, 2)
		& 16'h00FF)) ##1 ({8'h00, stack_byte} == ($past(current_pc, 3) >> 8)))
		else $error("pushed pc bytes wrong");
	chk_busy_span: assert property (s_accept |=> seq_busy [*3] ##1 !seq_busy)
		else $error("busy span wrong");
	chk_same_level: assert property (in_service_hi |-> !irq_pending)
		else $error("request taken over high routine");
	chk_high_preempt: assert property (in_service_lo && !in_service_hi && watchdog_flag
		&& !seq_busy |-> irq_pending)
		else $error("watchdog not preempting low routine");
	chk_wdt_high: assert property (pc_load && irq_ack[POLL_WDT] |-> in_service_hi
		&& pc_load_addr == 16'h005B)
		else $error("watchdog entry wrong");
	chk_wdt_irq: assert property (wdt_timeout && watchdog_irq_select
		&& wdt_timeout_setting != '0 |=> watchdog_flag && !wdt_reset_req)
		else $error("watchdog interrupt not raised");
	chk_wdt_zero: assert property (wdt_timeout && wdt_timeout_setting == '0
		&& !watchdog_flag |=> !watchdog_flag)
		else $error("watchdog raised with zero setting");
	chk_wdt_reset: assert property (wdt_timeout && !watchdog_irq_select |=> wdt_reset_req)
		else $error("watchdog reset missing");
	chk_return_hi: assert property (return_from_isr && in_service_hi && !seq_busy
		|=> !in_service_hi && $stable(in_service_lo))
		else $error("return did not clear high level");
endmodule : irq_ctrl_asserts

//--- bench/core_model.sv
/*
 * Behavioural core: always interruptible, collects pushed bytes, jumps.
 * Assumes stack_push and pc_load are one-cycle strobes on sys_clk.
 */
`timescale 1ns/1ps
module core_model (
	input  wire logic        sys_clk,        // core clock
	input  wire logic        stack_push,     // push strobe
	input  wire logic [7:0]  stack_byte,     // pushed byte
	input  wire logic        pc_load,        // vector strobe
	input  wire logic [15:0] pc_load_addr,   // vector
	output logic             instr_boundary, // interruptible
	output logic      [15:0] current_pc,     // running pc
	output logic      [15:0] saved_pc        // last two pushed bytes
);
	// ----------------------------------------
	// behaviour
	// ----------------------------------------
	initial instr_boundary = 1'b1;
	initial current_pc = 16'h1234;
	initial saved_pc = 16'h0000;
	// jump to the vector so a nested entry saves it
	always @(negedge sys_clk) if (pc_load) current_pc <= pc_load_addr;
	always @(posedge sys_clk) if (stack_push) saved_pc <= {stack_byte, saved_pc[15:8]};
endmodule : core_model

//--- bench/tb.sv
/*
 * Self-checking bench: register access, poll order, levels, watchdog.
 * Assumes the controller package and the core model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb
	import irq_ctrl_pkg::*;
;
	// ----------------------------------------
	// stimulus and tasks
	// ----------------------------------------
	logic sys_clk = 0, rst_b = 0, ce = 1, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_wdata = 0;
	logic wdt_timeout = 0, watchdog_irq_select = 0, return_from_isr = 0;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, bit_addr = 0, sfr_rdata, stack_byte;
	logic [3:0] wdt_timeout_setting = 0;
	logic [13:0] fl = 0;
	logic sfr_hit, watchdog_flag, wdt_reset_req, instr_boundary, irq_pending, stack_push;
	logic pc_load, in_service_hi, in_service_lo, seq_busy;
	logic [15:0] current_pc, pc_load_addr, saved_pc, pc_exp;
	logic [NUM_SRC-1:0] irq_ack;
	int num_errors = 0, samples_checked = 0;
	localparam int pidx [14] = '{0, 2, 3, 3, 4, 5, 6, 7, 7, 8, 8, 9, 9, 10};
	localparam logic [15:0] pvec [14] = '{16'h0043, 16'h0003, 16'h0033, 16'h0033, 16'h000B,
		16'h0013, 16'h001B, 16'h003B, 16'h003B, 16'h0023, 16'h0023, 16'h002B, 16'h002B, 16'h0053};
	always #5 sys_clk = ~sys_clk;
	two_level_interrupt_controller #(.WDT_SET_W(4)) dut_u (.*, .supply_monitor_flag(fl[0]),
		.ext0_flag(fl[1]), .main_converter_ready(fl[2]), .aux_converter_ready(fl[3]),
		.timer0_overflow(fl[4]), .ext1_flag(fl[5]), .timer1_overflow(fl[6]),
		.serial_periph_flag(fl[7]), .two_wire_flag(fl[8]), .uart_rx_done(fl[9]),
		.uart_tx_done(fl[10]), .timer2_overflow(fl[11]), .timer2_external_flag(fl[12]),
		.interval_counter_flag(fl[13]), .wdt_timeout(wdt_timeout));
	core_model core_u (.*);
	task automatic wr(input logic [7:0] a, d);
		@(negedge sys_clk);
		{sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
		@(negedge sys_clk);
		sfr_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, e);
		@(negedge sys_clk);
		{sfr_addr, sfr_rd} = {a, 1'b1};
		@(negedge sys_clk);
		sfr_rd = 1'b0;
		`CHK("sfr_rdata", e, sfr_rdata)
		`CHK("sfr_hit", (a == 8'hA8 || a == 8'hA9 || a == 8'hB8), sfr_hit)
	endtask : rd
	task automatic take(input int i, input logic [15:0] v, input logic hi);
		repeat (20) if (pc_load !== 1'b1) @(negedge sys_clk);
		`CHK("irq_ack", NUM_SRC'(1) << i, irq_ack)
		`CHK("pc_load_addr", v, pc_load_addr)
		`CHK("saved_pc", pc_exp, saved_pc)
		`CHK("in_service_hi", hi, in_service_hi)
		pc_exp = v;
	endtask : take
	task automatic ret();
		@(negedge sys_clk);
		return_from_isr = 1'b1;
		@(negedge sys_clk);
		return_from_isr = 1'b0;
	endtask : ret
	task automatic wd(input logic s, input logic [3:0] t);
		@(negedge sys_clk);
		{watchdog_irq_select, wdt_timeout_setting, wdt_timeout} = {s, t, 1'b1};
		@(negedge sys_clk);
		wdt_timeout = 1'b0;
	endtask : wd
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	initial
	begin
		pc_exp = 16'h1234;
		repeat (6) @(negedge sys_clk);
		rst_b = 1'b1;
		rd(8'hA8, 8'h00);
		rd(8'hA9, 8'hA0);
		rd(8'hB8, 8'h00);
		rd(8'hA0, 8'h00);
		wr(8'hB8, 8'hFF);
		rd(8'hB8, 8'h7F);
		wr(8'hB8, 8'h00);
		$display("test registers done");
		fl = 14'h3FFF;
		wr(8'hA8, 8'h7F);
		`CHK("irq_pending", 1'b0, irq_pending)
		wr(8'hA8, 8'h80);
		`CHK("irq_pending", 1'b0, irq_pending)
		wr(8'hA8, 8'h7F);
		wr(8'hA9, 8'h07);
		@(negedge sys_clk);
		{bit_addr, bit_wdata, bit_wr} = {8'hAF, 1'b1, 1'b1};
		@(negedge sys_clk);
		bit_wr = 1'b0;
		for (int i = 0; i < 14; i++)
		begin
			take(pidx[i], pvec[i], 1'b0);
			fl[i] = 1'b0;
			ret();
		end
		$display("test poll order done");
		wr(8'hB8, 8'h02);
		fl = 14'h0012;
		take(4, 16'h000B, 1'b1);
		fl[4] = 1'b0;
		`CHK("irq_pending", 1'b0, irq_pending)
		ret();
		take(2, 16'h0003, 1'b0);
		fl = 14'h0040;
		`CHK("irq_pending", 1'b0, irq_pending)
		wr(8'hA8, 8'h00);
		wd(1'b1, 4'h3);
		take(1, 16'h005B, 1'b1);
		`CHK("in_service_lo", 1'b1, in_service_lo)
		ret();
		ret();
		`CHK("in_service_lo", 1'b0, in_service_lo)
		wd(1'b1, 4'h0);
		`CHK("watchdog_flag", 1'b0, watchdog_flag)
		wd(1'b0, 4'h3);
		`CHK("wdt_reset_req", 1'b1, wdt_reset_req)
		$display("test levels and watchdog done");
		stop_test();
	end
	initial
	begin
		repeat (3000) @(posedge sys_clk);
		num_errors++;
		$display("watchdog expired");
		stop_test();
	end
endmodule : tb
bind two_level_interrupt_controller irq_ctrl_asserts #(.WDT_SET_W(WDT_SET_W)) chk_u (.*);
